// ---- rtl/rcp_ctrl.v ----
// Purpose: reset release, register initialisation, system clock and low-power control
// Assumes: oscillator edges arrive as synchronous strobes on CLOCK; cpu core drives bus
// Notes: timers 3/4 are modelled only as the stabilisation chain
//
// Notes on behaviour
// - after reset timers three and four chain, counting main oscillator over sixteen
// - reset release preloads ff and 07; internal reset ends on timer four overflow
// - direction, pull-up, edge, serial, timer mode and cpu mode registers clear
// - both interrupt request and both interrupt control registers clear at reset
// - converter control resets with only the conversion-finished flag set
// - program counter loads high byte from ffff and low byte from fffe
// - system clock is main oscillator divided by two by default
// - cpu mode bit 7 selects half the sub-oscillator as system clock
// - stop instruction halts both oscillators, system clock held high
// - entering stop forces the timer chain and preloads ff and 07
// - interrupt in stop restarts oscillation; clock held high until timer four overflows
// - wait instruction holds clock high, oscillator runs; interrupt resumes at once
// - cpu mode bit 6 stops main oscillator; clearing it restarts it
`timescale 1ns/1ps
`include "rcp_map.vh"
module rcp_ctrl
(
  // clock and reset
  input wire CLOCK,
  input wire NRST,
  // oscillator strobes, one cycle per oscillator edge
  input wire MAIN_OSC_TICK,
  input wire SUB_OSC_TICK,
  // cpu side
  input wire HALT_OSC_INSTR,
  input wire CLOCK_GATE_INSTR,
  input wire IRQ_WAKE,
  input wire [7:0] BUS_ADDR,
  input wire [7:0] BUS_WDATA,
  input wire BUS_WR,
  input wire [7:0] BUS_RDATA_IN,
  input wire ADC_DONE_SET,
  // outputs
  output reg [7:0] BUS_RDATA,
  output reg CPU_RESET_N,
  output reg PHI,
  output reg PHI_ENABLE,
  output reg MAIN_OSC_RUN,
  output reg SUB_OSC_RUN,
  output reg [15:0] VECTOR_ADDR,
  output reg VECTOR_FETCH_HI,
  output reg [7:0] PORT0_DIR,
  output reg [7:0] PORT1_DIR,
  output reg [7:0] PORT2_DIR,
  output reg [7:0] PORT4_DIR,
  output reg [7:0] PULLUP0,
  output reg [7:0] PULLUP1,
  output reg [7:0] EDGE_SEL,
  output reg [7:0] ADC_CTRL,
  output reg [7:0] SERIAL_MODE,
  output reg [7:0] T12_MODE,
  output reg [7:0] T34_MODE,
  output reg [7:0] TMODE2,
  output reg [7:0] CPU_MODE,
  output reg [7:0] IREQ1,
  output reg [7:0] IREQ2,
  output reg [7:0] ICTL1,
  output reg [7:0] ICTL2
);

  localparam ST_RESET = 3'd0;
  localparam ST_RUN = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_STOP = 3'd3;
  localparam ST_STAB = 3'd4;
  localparam ST_VEC_HI = 3'd5;
  localparam ST_VEC_LO = 3'd6;

  reg [2:0] state_q;
  reg [3:0] pre_q;
  reg [7:0] t3_q;
  reg [7:0] t4_q;
  reg div2_q;
  wire osc_tick;
  wire chain_run;
  wire pre_wrap;
  wire t4_ovf;

  // source of the phase clock
  assign osc_tick = CPU_MODE[`RCP_MODE_SUBCLK_BIT] ? SUB_OSC_TICK : MAIN_OSC_TICK;

  // chain counts only in reset and in the stabilisation wait after stop
  assign chain_run = (state_q == ST_RESET) || (state_q == ST_STAB);
  assign pre_wrap = MAIN_OSC_TICK && (pre_q == `RCP_PRESCALE_LAST);
  assign t4_ovf = chain_run && pre_wrap && (t3_q == 8'h00) && (t4_q == 8'h00);

  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      state_q <= ST_RESET;
      pre_q <= 4'h0;
      t3_q <= `RCP_T3_PRELOAD;
      t4_q <= `RCP_T4_PRELOAD;
      div2_q <= 1'b1;
    end
    else
    begin
      if (chain_run && MAIN_OSC_TICK)
        pre_q <= pre_q + 4'h1;
      if (chain_run && pre_wrap)
      begin
        t3_q <= t3_q - 8'h01;
        if (t3_q == 8'h00)
          t4_q <= t4_q - 8'h01;
      end
      // phase toggles on each selected oscillator edge, i.e. osc/2
      if (state_q == ST_RUN && osc_tick)
        div2_q <= ~div2_q;
      else if (state_q != ST_RUN)
        div2_q <= 1'b1;
      case (state_q)
        ST_RESET:
          if (t4_ovf)
            state_q <= ST_VEC_HI;
        ST_VEC_HI:
          state_q <= ST_VEC_LO;
        ST_VEC_LO:
          state_q <= ST_RUN;
        ST_RUN:
          if (HALT_OSC_INSTR)
          begin
            state_q <= ST_STOP;
            pre_q <= 4'h0;
            t3_q <= `RCP_T3_PRELOAD;
            t4_q <= `RCP_T4_PRELOAD;
          end
          else if (CLOCK_GATE_INSTR)
            state_q <= ST_WAIT;
        ST_WAIT:
          if (IRQ_WAKE)
            state_q <= ST_RUN;
        ST_STOP:
          if (IRQ_WAKE)
            state_q <= ST_STAB;
        ST_STAB:
          if (t4_ovf)
            state_q <= ST_RUN;
        default:
          state_q <= ST_RESET;
      endcase
    end
  end

  // registers initialised at reset and written by the cpu
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      PORT0_DIR <= `RCP_RST_ZERO;
      PORT1_DIR <= `RCP_RST_ZERO;
      PORT2_DIR <= `RCP_RST_ZERO;
      PORT4_DIR <= `RCP_RST_ZERO;
      PULLUP0 <= `RCP_RST_ZERO;
      PULLUP1 <= `RCP_RST_ZERO;
      EDGE_SEL <= `RCP_RST_ZERO;
      SERIAL_MODE <= `RCP_RST_ZERO;
      T12_MODE <= `RCP_RST_ZERO;
      T34_MODE <= `RCP_RST_ZERO;
      TMODE2 <= `RCP_RST_ZERO;
      CPU_MODE <= `RCP_RST_ZERO;
      IREQ1 <= `RCP_RST_ZERO;
      IREQ2 <= `RCP_RST_ZERO;
      ICTL1 <= `RCP_RST_ZERO;
      ICTL2 <= `RCP_RST_ZERO;
      ADC_CTRL <= `RCP_RST_ADC_CTRL;
    end
    else
    begin
      if (BUS_WR && PHI_ENABLE)
      begin
        case (BUS_ADDR)
          `RCP_ADDR_PORT0_DIR: PORT0_DIR <= BUS_WDATA;
          `RCP_ADDR_PORT1_DIR: PORT1_DIR <= BUS_WDATA;
          `RCP_ADDR_PORT2_DIR: PORT2_DIR <= BUS_WDATA;
          `RCP_ADDR_PORT4_DIR: PORT4_DIR <= BUS_WDATA;
          `RCP_ADDR_PULLUP0: PULLUP0 <= BUS_WDATA;
          `RCP_ADDR_PULLUP1: PULLUP1 <= BUS_WDATA;
          `RCP_ADDR_EDGE_SEL: EDGE_SEL <= BUS_WDATA;
          `RCP_ADDR_ADC_CTRL: ADC_CTRL <= BUS_WDATA;
          `RCP_ADDR_SERIAL_MODE: SERIAL_MODE <= BUS_WDATA;
          `RCP_ADDR_T12_MODE: T12_MODE <= BUS_WDATA;
          `RCP_ADDR_T34_MODE: T34_MODE <= BUS_WDATA;
          `RCP_ADDR_TMODE2: TMODE2 <= BUS_WDATA;
          `RCP_ADDR_CPU_MODE: CPU_MODE <= BUS_WDATA;
          `RCP_ADDR_IREQ1: IREQ1 <= BUS_WDATA;
          `RCP_ADDR_IREQ2: IREQ2 <= BUS_WDATA;
          `RCP_ADDR_ICTL1: ICTL1 <= BUS_WDATA;
          `RCP_ADDR_ICTL2: ICTL2 <= BUS_WDATA;
          default: ;
        endcase
      end
      // only a write to the converter register beats the done strobe,
      // so a write elsewhere in that cycle cannot lose the flag
      if (ADC_DONE_SET && !(BUS_WR && PHI_ENABLE && (BUS_ADDR == `RCP_ADDR_ADC_CTRL)))
        ADC_CTRL[`RCP_ADC_DONE_BIT] <= 1'b1;
    end
  end

  // outputs from flip-flops
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      CPU_RESET_N <= 1'b0;
      PHI <= 1'b1;
      PHI_ENABLE <= 1'b0;
      MAIN_OSC_RUN <= 1'b1;
      SUB_OSC_RUN <= 1'b1;
      VECTOR_ADDR <= `RCP_VECTOR_HI;
      VECTOR_FETCH_HI <= 1'b0;
      BUS_RDATA <= 8'h00;
    end
    else
    begin
      CPU_RESET_N <= (state_q != ST_RESET) && (state_q != ST_VEC_HI) && (state_q != ST_VEC_LO);
      // forced high at once outside run, the divider lags a cycle
      PHI <= (state_q == ST_RUN) ? div2_q : 1'b1;
      PHI_ENABLE <= (state_q == ST_RUN) && osc_tick && div2_q;
      // stop halts both; mode bit 6 halts the main one, no stabilisation count
      MAIN_OSC_RUN <= (state_q != ST_STOP) && !CPU_MODE[`RCP_MODE_MAINSTOP_BIT];
      SUB_OSC_RUN <= (state_q != ST_STOP);
      VECTOR_FETCH_HI <= (state_q == ST_VEC_HI);
      VECTOR_ADDR <= (state_q == ST_VEC_HI) ? `RCP_VECTOR_HI : `RCP_VECTOR_LO;
      BUS_RDATA <= (BUS_ADDR == `RCP_ADDR_CPU_MODE) ? CPU_MODE : BUS_RDATA_IN;
    end
  end

endmodule // rcp_ctrl

// ---- include/rcp_map.vh ----
// Purpose: constants for the reset, clock and power controller
// Assumes: 8-bit register bus from the cpu core, addresses in page zero
// Notes: header only, no logic
`ifndef RCP_MAP_VH
`define RCP_MAP_VH
`define RCP_ADDR_CPU_MODE 8'hfb
`define RCP_ADDR_PORT0_DIR 8'hc1
`define RCP_ADDR_PORT1_DIR 8'hc3
`define RCP_ADDR_PORT2_DIR 8'hc5
`define RCP_ADDR_PORT4_DIR 8'hc9
`define RCP_ADDR_PULLUP0 8'hd0
`define RCP_ADDR_PULLUP1 8'hd1
`define RCP_ADDR_EDGE_SEL 8'hd4
`define RCP_ADDR_ADC_CTRL 8'hd9
`define RCP_ADDR_SERIAL_MODE 8'hdc
`define RCP_ADDR_T12_MODE 8'hf8
`define RCP_ADDR_T34_MODE 8'hf9
`define RCP_ADDR_TMODE2 8'hfa
`define RCP_ADDR_IREQ1 8'hfc
`define RCP_ADDR_IREQ2 8'hfd
`define RCP_ADDR_ICTL1 8'hfe
`define RCP_ADDR_ICTL2 8'hff
`define RCP_RST_ZERO 8'h00
`define RCP_RST_ADC_CTRL 8'h08
`define RCP_ADC_DONE_BIT 3
`define RCP_MODE_SUBCLK_BIT 7
`define RCP_MODE_MAINSTOP_BIT 6
`define RCP_T3_PRELOAD 8'hff
`define RCP_T4_PRELOAD 8'h07
`define RCP_PRESCALE_DIV 16
// prescaler count at which it wraps, divide ratio minus one
`define RCP_PRESCALE_LAST 4'hf
`define RCP_VECTOR_HI 16'hffff
`define RCP_VECTOR_LO 16'hfffe
`define RCP_RESET_MIN_NS 2000
`define RCP_CLK_NS 40
`define RCP_RESET_MIN_CYC ((`RCP_RESET_MIN_NS + `RCP_CLK_NS - 1) / `RCP_CLK_NS)
`endif

// ---- verif/rcp_ctrl_asserts.sv ----
// Purpose: port assertions for rcp_ctrl
// Assumes: one CLOCK domain, NRST synchronous active low
// Notes: bound into rcp_ctrl below
`timescale 1ns/1ps
module rcp_asserts
(
  // clock, reset, bus
  input wire CLOCK,
  input wire NRST,
  input wire [7:0] BUS_ADDR,
  input wire [7:0] BUS_WDATA,
  input wire BUS_WR,
  input wire [7:0] BUS_RDATA,
  // state outputs
  input wire CPU_RESET_N,
  input wire PHI,
  input wire PHI_ENABLE,
  input wire MAIN_OSC_RUN,
  input wire SUB_OSC_RUN,
  input wire [15:0] VECTOR_ADDR,
  input wire VECTOR_FETCH_HI,
  input wire [7:0] ADC_CTRL,
  input wire [7:0] CPU_MODE,
  input wire [7:0] ICTL1
);
  default clocking @(posedge CLOCK); endclocking
  chk_reset_clear: assert property (!NRST |=> CPU_MODE == 8'h00 && ICTL1 == 8'h00)
    else $error("reset clear");
  chk_adc_reset: assert property (!NRST |=> ADC_CTRL == 8'h08)
    else $error("adc reset");
  chk_core_held: assert property (!NRST |=> !CPU_RESET_N && PHI && VECTOR_ADDR == 16'hffff)
    else $error("core held");
  chk_vector_pair: assert property (disable iff (!NRST)
    VECTOR_FETCH_HI |-> VECTOR_ADDR == 16'hffff ##1 VECTOR_ADDR == 16'hfffe) else $error("vector");
  chk_mode_write: assert property (disable iff (!NRST)
    BUS_WR && PHI_ENABLE && BUS_ADDR == 8'hfb |=> CPU_MODE == $past(BUS_WDATA)) else $error("write");
  chk_main_stop: assert property (disable iff (!NRST)
    $changed(CPU_MODE[6]) |=> MAIN_OSC_RUN == !CPU_MODE[6]) else $error("main stop");
  chk_stop_high: assert property (disable iff (!NRST)
    !MAIN_OSC_RUN && !SUB_OSC_RUN |-> PHI && !PHI_ENABLE) else $error("stop phase");
  chk_read_mode: assert property (disable iff (!NRST)
    BUS_ADDR == 8'hfb && !BUS_WR |=> BUS_RDATA == $past(CPU_MODE)) else $error("read");
  cover property ($rose(CPU_RESET_N));
  cover property ($fell(SUB_OSC_RUN));
  cover property ($fell(MAIN_OSC_RUN) && SUB_OSC_RUN);
endmodule // rcp_asserts

bind rcp_ctrl rcp_asserts chk_u (.*);

// ---- verif/reset_clock_power_control_tb.sv ----
// Purpose: self-checking bench for rcp_ctrl
// Assumes: main strobe every cycle while it runs, so each release count is 32768 cycles
// Notes: about 70000 cycles
`timescale 1ns/1ps
module reset_clock_power_control_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg st = 1'b1;
  reg halt = 1'b0;
  reg gate = 1'b0;
  reg irq = 1'b0;
  reg wr = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wd = 8'h00;
  reg p;
  reg adc = 1'b0;
  reg [7:0] amap [0:16];
  integer mv;
  wire [7:0] rd;
  wire rstn, phi, phien, mrun, srun, vhi;
  wire [15:0] va;
  wire [7:0] r [0:16];
  integer fails = 0;
  integer n_tests = 0;
  integer i;
  integer n;
  initial forever #20 clk = ~clk;
  rcp_ctrl dut_u
  (
    .CLOCK(clk), .NRST(nrst), .MAIN_OSC_TICK(mrun), .SUB_OSC_TICK(st), .HALT_OSC_INSTR(halt),
    .CLOCK_GATE_INSTR(gate), .IRQ_WAKE(irq), .BUS_ADDR(addr), .BUS_WDATA(wd), .BUS_WR(wr),
    .BUS_RDATA_IN(8'h5a), .ADC_DONE_SET(adc), .BUS_RDATA(rd), .CPU_RESET_N(rstn), .PHI(phi),
    .PHI_ENABLE(phien), .MAIN_OSC_RUN(mrun), .SUB_OSC_RUN(srun), .VECTOR_ADDR(va),
    .VECTOR_FETCH_HI(vhi), .PORT0_DIR(r[0]), .PORT1_DIR(r[1]), .PORT2_DIR(r[2]),
    .PORT4_DIR(r[3]), .PULLUP0(r[4]), .PULLUP1(r[5]), .EDGE_SEL(r[6]), .ADC_CTRL(r[7]),
    .SERIAL_MODE(r[8]), .T12_MODE(r[9]), .T34_MODE(r[10]), .TMODE2(r[11]), .CPU_MODE(r[12]),
    .IREQ1(r[13]), .IREQ2(r[14]), .ICTL1(r[15]), .ICTL2(r[16])
  );
  task final_report;
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge clk);
  endtask
  // counts edges until phien (sel) or vhi rises; a hang ends the run
  task wt(input sel);
    n = 0;
    while ((sel ? phien : vhi) !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n = n + 1;
    end
    if (n >= 40000)
    begin
      fails = fails + 1;
      final_report;
    end
  endtask
  // counts phase changes over eight clocks
  task ntog;
    mv = 0;
    p = phi;
    repeat (8)
    begin
      @(posedge clk);
      if (phi !== p)
        mv = mv + 1;
      p = phi;
    end
  endtask
  // write held until an enabled phase edge takes it
  task wreg(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n = n + 1;
    end
    while (phien !== 1'b1 && n < 64);
    wr <= 1'b0;
    if (phien !== 1'b1)
    begin
      fails = fails + 1;
      final_report;
    end
    cyc(2);
  endtask
  task wcm(input [7:0] d);
    wreg(8'hfb, d);
    chk("mode", {8'h00, d}, {8'h00, r[12]});
    chk("mainrun", {15'h0, !d[6]}, {15'h0, mrun});
  endtask
  task pulse(input integer which);
    @(posedge clk);
    if (which == 0)
      halt <= 1'b1;
    else if (which == 1)
      gate <= 1'b1;
    else
      irq <= 1'b1;
    @(posedge clk);
    {halt, gate, irq} <= 3'b000;
    cyc(2);
  endtask
  task t_reset;
    cyc(5);
    for (i = 0; i < 17; i = i + 1)
      chk("reg", (i == 7) ? 16'h0008 : 16'h0000, {8'h00, r[i]});
    chk("rstn", 16'h0, {15'h0, rstn});
    cyc(45);
    nrst <= 1'b1;
    wt(1'b0);
    chk("rel", 16'h1, {15'h0, n >= 32768 && n < 32776});
    chk("vhi", 16'hffff, va);
    @(posedge clk);
    chk("vlo", 16'hfffe, va);
    cyc(4);
    chk("rstn", 16'h1, {15'h0, rstn});
  endtask
  task t_mode;
    st <= 1'b0;
    ntog;
    chk("main phi", 16'h8, mv[15:0]);
    wcm(8'h80);
    ntog;
    chk("sub idle", 16'h0, mv[15:0]);
    st <= 1'b1;
    cyc(2);
    ntog;
    chk("sub phi", 16'h8, mv[15:0]);
    wcm(8'hc0);
    chk("read", 16'hc0, {8'h00, rd});
    addr <= 8'h10;
    cyc(2);
    chk("pass", 16'h5a, {8'h00, rd});
    wcm(8'h80);
    cyc(16);
    wcm(8'h00);
  endtask
  task t_regs;
    amap[0] = 8'hc1;
    amap[1] = 8'hc3;
    amap[2] = 8'hc5;
    amap[3] = 8'hc9;
    amap[4] = 8'hd0;
    amap[5] = 8'hd1;
    amap[6] = 8'hd4;
    amap[7] = 8'hd9;
    amap[8] = 8'hdc;
    amap[9] = 8'hf8;
    amap[10] = 8'hf9;
    amap[11] = 8'hfa;
    amap[12] = 8'hfb;
    amap[13] = 8'hfc;
    amap[14] = 8'hfd;
    amap[15] = 8'hfe;
    amap[16] = 8'hff;
    // cpu mode is left alone here, it steers the phase clock
    for (i = 0; i < 17; i = i + 1)
      if (i != 12)
        wreg(amap[i], 8'ha0 + i[7:0]);
    for (i = 0; i < 17; i = i + 1)
      chk("reg wr", (i == 12) ? 16'h0000 : {8'h00, 8'ha0 + i[7:0]}, {8'h00, r[i]});
    @(posedge clk);
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    cyc(2);
    chk("adc done", 16'h00af, {8'h00, r[7]});
  endtask
  task t_low;
    wreg(8'hfe, 8'h01);
    pulse(1);
    ntog;
    chk("wait", 16'h0, mv[15:0]);
    chk("wait osc", 16'h3, {14'h0, mrun, phi});
    pulse(2);
    ntog;
    chk("resume", 16'h8, mv[15:0]);
    pulse(0);
    ntog;
    chk("stop", 16'h1, {13'h0, mrun, srun, mv != 0, phi});
    pulse(2);
    chk("restart", 16'h6, {13'h0, mrun, phi, phien});
    wt(1'b1);
    chk("wake", 16'h1, {15'h0, n >= 32760 && n < 32776});
  endtask
  initial
  begin
    t_reset;
    t_mode;
    t_regs;
    t_low;
    final_report;
  end
endmodule // reset_clock_power_control_tb
